// ### core/dacd_regs.svh
// Register offsets, field positions and reset values of the compare and decrement datapath
`ifndef DACD_REGS_SVH
`define DACD_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define DACD_ADDR_ACC_A   8'h00
`define DACD_ADDR_ACC_B   8'h04
`define DACD_ADDR_ACC_C   8'h08
`define DACD_ADDR_ACC_D   8'h0C
`define DACD_ADDR_FLAGS   8'h10
`define DACD_ADDR_STATUS  8'h14

// ==========================================================================
// Flag register fields
`define DACD_FLAG_C_BIT   0
`define DACD_FLAG_Z_BIT   1
`define DACD_FLAG_V_BIT   2
`define DACD_FLAG_N_BIT   3

// ==========================================================================
// Status register fields
`define DACD_STAT_BUSY_BIT  0
`define DACD_STAT_COUNT_LSB 8
`define DACD_STAT_COUNT_MSB 15

// ==========================================================================
// Reset values
`define DACD_ACC_RST      24'h000000
`define DACD_FLAGS_RST    4'h0
`define DACD_RDATA_RST    32'h00000000
`define DACD_COUNT_RST    8'h00

`endif

// ### core/dacd_pkg.sv
// Types shared by the compare and decrement datapath
package dacd_pkg;

  // ========================================================================
  // Operations issued by the host pipeline
  typedef enum logic [1:0] {
    DACD_OP_ACCUMULATOR_COMPARE,
    DACD_OP_COMPARE_PMOVE,
    DACD_OP_DECREMENT_WITH_CARRY,
    DACD_OP_DECREMENT_WITH_CARRY_IF_T
  } dacd_op_e;

  // ========================================================================
  // Operand sources of the compare
  typedef enum logic [1:0] {
    DACD_SRC_SIMM5,
    DACD_SRC_SIMM16,
    DACD_SRC_ACC,
    DACD_SRC_REG16
  } dacd_src_e;

  // ========================================================================
  // Issue state
  typedef enum logic {
    DACD_ST_IDLE,
    DACD_ST_WAIT_EXT
  } dacd_state_e;

  // ========================================================================
  // First instruction word, decoded
  typedef struct packed {
    dacd_op_e   op;
    logic [1:0] an;
    dacd_src_e  src;
    logic [1:0] am;
    logic       cj;
    logic [4:0] imm5;
  } dacd_insn_s;

  // ========================================================================
  // Arithmetic flags
  typedef struct packed {
    logic n;
    logic v;
    logic z;
    logic c;
  } dacd_flags_s;

endpackage : dacd_pkg

// ### core/dacd_operand_ext.sv
// Operand selection and width extension for the compare
`timescale 1ns/100ps
`default_nettype none

module dacd_operand_ext
  import dacd_pkg::*;
#(
  parameter int W = 24
) (
  // Selection
  input  wire dacd_src_e    src,
  // Candidate operands
  input  wire logic [4:0]   imm5,
  input  wire logic [15:0]  imm16,
  input  wire logic [W-1:0] acc_val,
  input  wire logic [15:0]  reg16,
  // Extended operand
  output logic      [W-1:0] operand
);

  // ========================================================================
  // Extension
  always_comb begin
    unique case (src)
      DACD_SRC_SIMM5:  operand = {{(W-5){imm5[4]}}, imm5};
      DACD_SRC_SIMM16: operand = {{(W-16){imm16[15]}}, imm16};
      DACD_SRC_ACC:    operand = acc_val;
      DACD_SRC_REG16:  operand = {{(W-16){1'b0}}, reg16};
    endcase
  end

endmodule // dacd_operand_ext

`default_nettype wire

// ### core/dacd_adder.sv
// Full-width adder with carry, zero, overflow and negative flags
`timescale 1ns/100ps
`default_nettype none

module dacd_adder
  import dacd_pkg::*;
#(
  parameter int W = 24
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  // Result
  output logic      [W-1:0] sum,
  output dacd_flags_s       flags
);

  logic [W:0] wide;

  // ========================================================================
  // Sum and flags
  always_comb begin
    wide    = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    sum     = wide[W-1:0];
    flags.c = wide[W];
    flags.z = (wide[W-1:0] == '0);
    flags.v = (a[W-1] == b[W-1]) && (wide[W-1] != a[W-1]);
    flags.n = flags.v ^ wide[W-1];
  end

endmodule // dacd_adder

`default_nettype wire

// ### core/dsp_acc_compare_decrement.sv
// Accumulator compare and decrement-with-carry datapath
//
// Function
// - Compare subtracts operand for flags only; accumulator keeps its value.
// - Short and long immediates are sign-extended to 24 bits.
// - A 16-bit register operand is zero-extended to 24 bits.
// - Carry is set when the operation carries out, else cleared.
// - Zero is set when the 24-bit result is zero, else cleared.
// - Overflow is set on signed overflow, else cleared.
// - Negative equals overflow XOR result MSB.
// - Compare is one word, two words with long immediate.
// - Parallel compare subtracts C or D from A or B, A/B unchanged.
// - Parallel compare also loads C or D from memory data.
// - Decrement subtracts inverted carry from selected 24-bit accumulator.
// - Conditional decrement runs only with T set, else changes nothing.
// - Accumulators, results and flags use the full 24-bit width.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none

`include "dacd_regs.svh"

module dsp_acc_compare_decrement
  import dacd_pkg::*;
#(
  parameter int W    = 24,
  parameter int NACC = 4
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Instruction issue from host pipeline
  input  wire logic         insn_valid,
  input  wire dacd_insn_s   insn,
  input  wire logic         ext_valid,
  input  wire logic [15:0]  ext_word,
  // Operand sources from host
  input  wire logic [15:0]  reg16_data,
  input  wire logic [W-1:0] mem_rdata,
  input  wire logic         t_flag,
  // Register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  // Status to host
  output logic              busy,
  output logic              done,
  output dacd_flags_s       flags_out
);

  // ========================================================================
  // State
  dacd_state_e       state_reg;
  dacd_state_e       state_next;
  dacd_insn_s        held_reg;
  logic [W-1:0]      acc_reg [NACC];
  dacd_flags_s       flags_reg;
  logic              done_reg;
  logic [7:0]        count_reg;
  logic [31:0]       rdata_reg;
  logic              busy_reg;

  // ========================================================================
  // Decode of the active instruction
  dacd_insn_s        cur;
  logic              take_insn;
  logic              take_ext;
  logic              exec;
  logic              needs_ext;
  logic [1:0]        dst_idx;
  logic [1:0]        src_idx;
  logic [1:0]        load_idx;
  logic [W-1:0]      a_val;
  logic [W-1:0]      src_acc_val;
  logic [W-1:0]      operand;
  logic [W-1:0]      add_b;
  logic              add_cin;
  logic [W-1:0]      sum;
  dacd_flags_s       add_flags;
  logic              write_acc;
  logic              write_load;
  logic              write_flags;

  assign take_insn = insn_valid && (state_reg == DACD_ST_IDLE);
  assign take_ext  = ext_valid && (state_reg == DACD_ST_WAIT_EXT);
  assign needs_ext = (insn.op == DACD_OP_ACCUMULATOR_COMPARE) &&
                     (insn.src == DACD_SRC_SIMM16);
  assign cur       = (state_reg == DACD_ST_WAIT_EXT) ? held_reg : insn;
  assign exec      = (take_insn && !needs_ext) || take_ext;

  always_comb begin
    dst_idx  = cur.an;
    src_idx  = cur.am;
    load_idx = {1'b1, cur.cj};
    if (cur.op == DACD_OP_COMPARE_PMOVE) begin
      dst_idx = {1'b0, cur.an[0]};
      src_idx = {1'b1, cur.am[0]};
    end
  end

  assign a_val       = acc_reg[dst_idx];
  assign src_acc_val = acc_reg[src_idx];

  // ========================================================================
  // Operand extension
  dacd_operand_ext #(
    .W       (W)
  ) u_ext (
    .src     ((cur.op == DACD_OP_COMPARE_PMOVE) ? DACD_SRC_ACC : cur.src),
    .imm5    (cur.imm5),
    .imm16   (ext_word),
    .acc_val (src_acc_val),
    .reg16   (reg16_data),
    .operand (operand)
  );

  // ========================================================================
  // Adder input: subtract as A + ~op + 1, decrement as A + all-ones + C
  always_comb begin
    unique case (cur.op)
      DACD_OP_ACCUMULATOR_COMPARE,
      DACD_OP_COMPARE_PMOVE: begin
        add_b   = ~operand;
        add_cin = 1'b1;
      end
      DACD_OP_DECREMENT_WITH_CARRY,
      DACD_OP_DECREMENT_WITH_CARRY_IF_T: begin
        add_b   = {W{1'b1}};
        add_cin = flags_reg.c;
      end
    endcase
  end

  dacd_adder #(
    .W     (W)
  ) u_add (
    .a     (a_val),
    .b     (add_b),
    .cin   (add_cin),
    .sum   (sum),
    .flags (add_flags)
  );

  // ========================================================================
  // Write enables
  always_comb begin
    write_acc   = 1'b0;
    write_load  = 1'b0;
    write_flags = 1'b0;
    if (exec) begin
      unique case (cur.op)
        DACD_OP_ACCUMULATOR_COMPARE: begin
          write_flags = 1'b1;
        end
        DACD_OP_COMPARE_PMOVE: begin
          write_flags = 1'b1;
          write_load  = 1'b1;
        end
        DACD_OP_DECREMENT_WITH_CARRY: begin
          write_acc   = 1'b1;
          write_flags = 1'b1;
        end
        DACD_OP_DECREMENT_WITH_CARRY_IF_T: begin
          write_acc   = t_flag;
          write_flags = t_flag;
        end
      endcase
    end
  end

  // ========================================================================
  // Issue state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DACD_ST_IDLE: begin
        if (take_insn && needs_ext) begin
          state_next = DACD_ST_WAIT_EXT;
        end
      end
      DACD_ST_WAIT_EXT: begin
        if (ext_valid) begin
          state_next = DACD_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= DACD_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Busy flag, registered beside the state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next == DACD_ST_WAIT_EXT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      held_reg <= '0;
    end else if (take_insn) begin
      held_reg <= insn;
    end
  end

  // ========================================================================
  // Accumulators: instruction writes win over register port writes
  for (genvar i = 0; i < NACC; i++) begin : g_acc
    localparam logic [7:0] ACC_ADDR = 8'(i * 4);
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        acc_reg[i] <= `DACD_ACC_RST;
      end else if (write_acc && (dst_idx == 2'(i))) begin
        acc_reg[i] <= sum;
      end else if (write_load && (load_idx == 2'(i))) begin
        acc_reg[i] <= mem_rdata;
      end else if (reg_wr && (reg_addr == ACC_ADDR)) begin
        acc_reg[i] <= reg_wdata[W-1:0];
      end
    end
  end

  // ========================================================================
  // Flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_reg <= `DACD_FLAGS_RST;
    end else if (write_flags) begin
      flags_reg <= add_flags;
    end else if (reg_wr && (reg_addr == `DACD_ADDR_FLAGS)) begin
      flags_reg.c <= reg_wdata[`DACD_FLAG_C_BIT];
      flags_reg.z <= reg_wdata[`DACD_FLAG_Z_BIT];
      flags_reg.v <= reg_wdata[`DACD_FLAG_V_BIT];
      flags_reg.n <= reg_wdata[`DACD_FLAG_N_BIT];
    end
  end

  // ========================================================================
  // Completion pulse and counter of flag-writing instructions
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= exec;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg <= `DACD_COUNT_RST;
    end else if (reg_wr && (reg_addr == `DACD_ADDR_STATUS)) begin
      count_reg <= `DACD_COUNT_RST;
    end else if (write_flags) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // ========================================================================
  // Register read port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= `DACD_RDATA_RST;
    end else if (reg_rd) begin
      rdata_reg <= `DACD_RDATA_RST;
      unique case (reg_addr)
        `DACD_ADDR_ACC_A: rdata_reg[W-1:0] <= acc_reg[0];
        `DACD_ADDR_ACC_B: rdata_reg[W-1:0] <= acc_reg[1];
        `DACD_ADDR_ACC_C: rdata_reg[W-1:0] <= acc_reg[2];
        `DACD_ADDR_ACC_D: rdata_reg[W-1:0] <= acc_reg[3];
        `DACD_ADDR_FLAGS: begin
          rdata_reg[`DACD_FLAG_C_BIT] <= flags_reg.c;
          rdata_reg[`DACD_FLAG_Z_BIT] <= flags_reg.z;
          rdata_reg[`DACD_FLAG_V_BIT] <= flags_reg.v;
          rdata_reg[`DACD_FLAG_N_BIT] <= flags_reg.n;
        end
        `DACD_ADDR_STATUS: begin
          rdata_reg[`DACD_STAT_BUSY_BIT] <= (state_reg == DACD_ST_WAIT_EXT);
          rdata_reg[`DACD_STAT_COUNT_MSB:`DACD_STAT_COUNT_LSB] <= count_reg;
        end
        default: rdata_reg <= `DACD_RDATA_RST;
      endcase
    end else begin
      rdata_reg <= `DACD_RDATA_RST;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign busy      = busy_reg;
  assign done      = done_reg;
  assign flags_out = flags_reg;

endmodule // dsp_acc_compare_decrement

`default_nettype wire

// ### verif/dacd_check_monitor.sv
// Port-level assertions for the compare and decrement datapath
`timescale 1ns/100ps
`default_nettype none

module dacd_check_monitor
  import dacd_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Issue side
  input wire logic        insn_valid,
  input wire dacd_insn_s  insn,
  input wire logic        ext_valid,
  input wire logic        t_flag,
  input wire logic        reg_wr,
  // Status
  input wire logic        busy,
  input wire logic        done,
  input wire dacd_flags_s flags_out
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic lng;
  assign take = insn_valid && !busy;
  assign lng  = insn.op == DACD_OP_ACCUMULATOR_COMPARE && insn.src == DACD_SRC_SIMM16;

  // ==========================================================================
  // Checks
  a_short_done: assert property (take && !lng |=> done && !busy)
    else $error("one-word op gave no done");
  a_long_busy: assert property (take && lng |=> busy && !done)
    else $error("long immediate did not wait");
  a_ext_done: assert property (busy && ext_valid |=> done && !busy)
    else $error("second word not completed");
  a_busy_wait: assert property (busy && !ext_valid |=> busy && !done)
    else $error("busy dropped without second word");
  a_self_cmp: assert property (take && insn.op == DACD_OP_ACCUMULATOR_COMPARE
    && insn.src == DACD_SRC_ACC && insn.am == insn.an && !reg_wr |=> flags_out == 4'h3)
    else $error("self compare flags wrong");
  a_cond_nop: assert property (take && insn.op == DACD_OP_DECREMENT_WITH_CARRY_IF_T && !t_flag
    && !reg_wr |=> $stable(flags_out) && done)
    else $error("conditional op changed flags");
  a_flags_idle: assert property (!take && !(busy && ext_valid) && !reg_wr |=> $stable(flags_out))
    else $error("flags changed with no op");
  a_dec_carry: assert property (take && insn.op == DACD_OP_DECREMENT_WITH_CARRY
    && flags_out.c && !reg_wr |=> flags_out.c && !flags_out.v)
    else $error("decrement with carry set wrong");
endmodule // dacd_check_monitor

bind dsp_acc_compare_decrement dacd_check_monitor u_mon (
  .ref_clk    (ref_clk),
  .rst_n      (rst_n),
  .insn_valid (insn_valid),
  .insn       (insn),
  .ext_valid  (ext_valid),
  .t_flag     (t_flag),
  .reg_wr     (reg_wr),
  .busy       (busy),
  .done       (done),
  .flags_out  (flags_out)
);

`default_nettype wire

// ### verif/dacd_host_model.sv
// Host pipeline model that issues instruction words
`timescale 1ns/100ps
`default_nettype none

module dacd_host_model
  import dacd_pkg::*;
(
  // Clock
  input  wire logic   ref_clk,
  // Issue
  output logic        insn_valid,
  output dacd_insn_s  insn,
  output logic        ext_valid,
  output logic [15:0] ext_word,
  // Operands
  output logic [15:0] reg16_data,
  output logic [23:0] mem_rdata,
  output logic        t_flag
);
  // ==========================================================================
  // Issue one instruction, second word for a long immediate
  initial begin
    insn_valid = 1'b0;
    insn       = '0;
    ext_valid  = 1'b0;
    ext_word   = 16'hA5A5;
    reg16_data = 16'h5A5A;
    mem_rdata  = 24'hC3C3C3;
    t_flag     = 1'b0;
  end

  task automatic issue(input dacd_insn_s w, input logic [15:0] x, r, input logic [23:0] m, input logic t);
    logic       lng;
    dacd_insn_s busy_w;
    lng       = (w.op == DACD_OP_ACCUMULATOR_COMPARE) && (w.src == DACD_SRC_SIMM16);
    busy_w    = dacd_insn_s'(~w);
    busy_w.op = DACD_OP_DECREMENT_WITH_CARRY;
    @(posedge ref_clk);
    insn_valid <= 1'b1;
    insn       <= w;
    reg16_data <= r;
    mem_rdata  <= m;
    t_flag     <= t;
    @(posedge ref_clk);
    // Word offered while busy must be refused
    insn_valid <= lng;
    insn       <= busy_w;
    reg16_data <= ~r;
    mem_rdata  <= ~m;
    if (lng) begin
      @(posedge ref_clk);
      insn_valid <= 1'b0;
      ext_valid <= 1'b1;
      ext_word  <= x;
      @(posedge ref_clk);
      ext_valid <= 1'b0;
      ext_word  <= ~x;
    end
  endtask
endmodule // dacd_host_model

`default_nettype wire

// ### verif/tb_top.sv
// Testbench for the compare and decrement datapath
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import dacd_pkg::*;
  // ==========================================================================
  // Signals and model state
  localparam dacd_op_e CMP  = DACD_OP_ACCUMULATOR_COMPARE;
  localparam dacd_op_e PMV  = DACD_OP_COMPARE_PMOVE;
  localparam dacd_op_e DEC  = DACD_OP_DECREMENT_WITH_CARRY;
  localparam dacd_op_e DECT = DACD_OP_DECREMENT_WITH_CARRY_IF_T;
  logic        ref_clk = 1'b0;
  logic        rst_n, reg_wr, reg_rd, insn_valid, ext_valid, t_flag, busy, done;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] ext_word, reg16_data;
  logic [23:0] mem_rdata;
  logic [23:0] acc [4];
  logic [3:0]  flg;
  dacd_insn_s  insn;
  dacd_flags_s flags_out;
  int          miscompares, n_compared;

  always #25 ref_clk = ~ref_clk;

  dacd_host_model host (.ref_clk(ref_clk), .insn_valid(insn_valid), .insn(insn), .ext_valid(ext_valid),
    .ext_word(ext_word), .reg16_data(reg16_data), .mem_rdata(mem_rdata), .t_flag(t_flag));
  dsp_acc_compare_decrement DUT (.ref_clk(ref_clk), .rst_n(rst_n), .insn_valid(insn_valid), .insn(insn),
    .ext_valid(ext_valid), .ext_word(ext_word), .reg16_data(reg16_data), .mem_rdata(mem_rdata),
    .t_flag(t_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .busy(busy), .done(done), .flags_out(flags_out));

  // ==========================================================================
  // Reference arithmetic, returns {n,v,z,c,sum}
  function automatic logic [27:0] add_ref(input logic [23:0] a, b, input logic ci);
    logic [24:0] s;
    logic        v;
    s = {1'b0, a} + {1'b0, b} + {24'h0, ci};
    v = (a[23] == b[23]) && (s[23] != a[23]);
    return {v ^ s[23], v, s[23:0] == 24'h0, s[24], s[23:0]};
  endfunction

  // ==========================================================================
  // Access tasks
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a < 8'h10) acc[a[3:2]] = v[23:0];
    else if (a == 8'h10) flg = v[3:0];
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask

  task automatic chk_state(input string nm);
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4), v);
      check("accumulator", v, {8'h00, acc[i]});
    end
    rd(8'h10, v);
    check("flags", v, {28'h0, flg});
    check("flags_out", {28'h0, flags_out}, {28'h0, flg});
    $display("test %s done", nm);
  endtask

  task automatic exec(input dacd_op_e op, input logic [1:0] an, input dacd_src_e src = DACD_SRC_SIMM5,
    input logic [1:0] am = 2'd0, input logic t = 1'b0, input logic cj = 1'b0, input logic [4:0] i5 = 5'h00,
    input logic [15:0] x = 16'h0000, input logic [15:0] r = 16'h0000, input logic [23:0] m = 24'h000000);
    dacd_insn_s  w;
    logic [23:0] b;
    logic [27:0] s;
    w = '{op, an, src, am, cj, i5};
    host.issue(w, x, r, m, t);
    @(negedge ref_clk);
    check("done", {31'h0, done}, 32'h1);
    case (src)
      DACD_SRC_SIMM5:  b = {{19{i5[4]}}, i5};
      DACD_SRC_SIMM16: b = {{8{x[15]}}, x};
      DACD_SRC_ACC:    b = acc[am];
      default:         b = {8'h00, r};
    endcase
    if (op == CMP) begin
      s   = add_ref(acc[an], ~b, 1'b1);
      flg = s[27:24];
    end else if (op == PMV) begin
      s   = add_ref(acc[an[0]], ~acc[{1'b1, am[0]}], 1'b1);
      flg = s[27:24];
      acc[{1'b1, cj}] = m;
    end else if (op == DEC || t) begin
      s       = add_ref(acc[an], 24'hFFFFFF, flg[0]);
      flg     = s[27:24];
      acc[an] = s[23:0];
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    final_report;
  end

  initial begin
    rst_n       = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    miscompares = 0;
    n_compared  = 0;
    flg         = 4'h0;
    foreach (acc[k]) acc[k] = 24'h0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_state("reset");
    wr(8'h00, 32'h007FFFFF);
    wr(8'h04, 32'h00000010);
    wr(8'h08, 32'h00800000);
    wr(8'h0C, 32'h00000001);
    rd(8'h20, d);
    check("unmapped", d, 32'h0);
    exec(CMP, 2'd0, DACD_SRC_SIMM5, 2'd0, 1'b0, 1'b0, 5'h10);
    chk_state("cmp_simm5");
    exec(CMP, 2'd1, DACD_SRC_SIMM16, 2'd0, 1'b0, 1'b0, 5'h00, 16'h8000);
    chk_state("cmp_simm16");
    exec(CMP, 2'd2, DACD_SRC_REG16, 2'd0, 1'b0, 1'b0, 5'h00, 16'h0000, 16'h8000);
    chk_state("cmp_reg16");
    exec(CMP, 2'd3, DACD_SRC_ACC, 2'd0);
    chk_state("cmp_acc");
    exec(CMP, 2'd3, DACD_SRC_ACC, 2'd3);
    chk_state("cmp_self");
    exec(PMV, 2'd1, DACD_SRC_ACC, 2'd0, 1'b0, 1'b1, 5'h00, 16'h0000, 16'h0000, 24'h123456);
    chk_state("cmp_pmove");
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'h0);
    exec(DEC, 2'd3);
    exec(DEC, 2'd3);
    chk_state("dec_wrap");
    wr(8'h10, 32'h1);
    exec(DEC, 2'd0);
    chk_state("dec_carry");
    wr(8'h00, 32'h00800000);
    wr(8'h10, 32'h0);
    exec(DEC, 2'd0);
    chk_state("dec_overflow");
    exec(DECT, 2'd1, DACD_SRC_SIMM5, 2'd0, 1'b0);
    chk_state("dec_t_clear");
    exec(DECT, 2'd1, DACD_SRC_SIMM5, 2'd0, 1'b1);
    chk_state("dec_t_set");
    rd(8'h14, d);
    check("status", d, 32'h00000B00);
    wr(8'h14, 32'h0);
    rd(8'h14, d);
    check("status_clear", d, 32'h0);
    $display("test status done");
    final_report;
  end
endmodule // tb_top

`default_nettype wire
